/* File: bchr_pkg.sv */
// Purpose: constants and types for the bridge configuration header register bank
// Assumes: 32-bit APB, byte offsets as printed
// Notes: only the revision value is a parameter in the top module; class codes are constants here
package bchr_pkg;
  localparam logic [7:0] BCHR_OFF_CLASS = 8'h08;
  localparam logic [7:0] BCHR_OFF_CACHE = 8'h0C;
  localparam logic [7:0] BCHR_OFF_RSV0 = 8'h10;
  localparam logic [7:0] BCHR_OFF_RSV1 = 8'h14;
  localparam logic [7:0] BCHR_OFF_BUS = 8'h18;
  localparam logic [7:0] BCHR_OFF_IO = 8'h1C;
  localparam logic [7:0] BCHR_OFF_LEGACY = 8'h98;
  localparam logic [7:0] BCHR_PROGIF_OFF = 8'h00;
  localparam logic [7:0] BCHR_PROGIF_ON = 8'h01;
  localparam logic [7:0] BCHR_SUBCLASS = 8'h04;
  localparam logic [7:0] BCHR_BASECLASS = 8'h06;
  localparam logic [7:0] BCHR_CACHE_MASK = 8'h3C;
  localparam logic [7:0] BCHR_PRI_LAT = 8'h00;
  localparam logic [6:0] BCHR_HDR_LAYOUT = 7'h01;
  localparam logic BCHR_MULTI_FN = 1'b0;
  localparam logic [7:0] BCHR_SELF_TEST = 8'h00;
  localparam logic [7:0] BCHR_BUS_RESET = 8'h00;
  localparam logic [7:0] BCHR_SEC_LAT_RESET = 8'h40;
  localparam logic [1:0] BCHR_IO_ADDR32 = 2'h1;
  localparam logic [3:0] BCHR_IO_BASE_RESET = 4'h0;
  localparam logic [3:0] BCHR_CACHE_RESET = 4'h0;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } bchr_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bchr_apb_rsp_t;

  typedef struct packed {
    logic [7:0] upstreamBus;
    logic [7:0] downstreamBus;
    logic [7:0] highestBus;
    logic [7:0] downstreamLatency;
    logic [3:0] ioBase;
    logic [3:0] cacheLine;
    logic legacyDecode;
  } bchr_cfg_t;
endpackage

/* File: bchr_regs.sv */
// Purpose: APB register bank for the bridge configuration header, offsets 08h to 1Ch and 98h
// Assumes: single clock, asynchronous active-low reset, one wait state per access
// Notes: unmapped reads return zero without error
// Notes: writes land at the edge that completes the access
`timescale 1ns/1ps
// Notes on behaviour
// - prog interface follows legacy bit, not writable
// - cache bits 5:2 writable, reset zero
// - cache bits 1:0, 7:6 read zero
// - primary latency timer reads 00h
// - header layout 01h, single function
// - offsets 10h to 17h unimplemented
// - three writable bus numbers, reset 00h
// - secondary latency timer writable, reset 40h
// - io base low nibble reads 0001
// - io base upper nibble writable, reset 0
// - subclass 04h, base class 06h fixed
module bchr_regs #(
  parameter logic [7:0] REVISION = 8'hA7 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire bchr_pkg::bchr_apb_req_t apbReq,
  output bchr_pkg::bchr_apb_rsp_t apbRsp,
  output bchr_pkg::bchr_cfg_t cfgOut
);
  import bchr_pkg::*;

  logic [3:0] cacheLine_reg;
  logic [7:0] upBus_reg;
  logic [7:0] downBus_reg;
  logic [7:0] highBus_reg;
  logic [7:0] secLat_reg;
  logic [3:0] ioBase_reg;
  logic legacy_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic [31:0] rdNext;
  logic [7:0] progIf;
  logic wrEn;
  logic access;
  logic done;
  logic pslverr_reg;
  logic [7:0] cacheByte;
  logic [7:0] priLatByte;
  logic [7:0] hdrByte;
  logic [7:0] ioByte;

  // access phase before the answer, and the completing edge
  assign access = apbReq.psel && apbReq.penable && !pready_reg;
  assign done = apbReq.psel && apbReq.penable && pready_reg;
  assign wrEn = done && apbReq.pwrite;
  assign progIf = legacy_reg ? BCHR_PROGIF_ON : BCHR_PROGIF_OFF;
  assign cacheByte = {2'h0, cacheLine_reg, 2'h0};
  assign priLatByte = BCHR_PRI_LAT;
  assign hdrByte = {BCHR_MULTI_FN, BCHR_HDR_LAYOUT};
  assign ioByte = {ioBase_reg, 2'h0, BCHR_IO_ADDR32};

  // read mux
  always_comb begin
    rdNext = 32'h00000000;
    case (apbReq.paddr)
      BCHR_OFF_CLASS: rdNext = {BCHR_BASECLASS, BCHR_SUBCLASS, progIf, REVISION};
      BCHR_OFF_CACHE: rdNext = {BCHR_SELF_TEST, hdrByte, priLatByte, cacheByte};
      BCHR_OFF_BUS: rdNext = {secLat_reg, highBus_reg, downBus_reg, upBus_reg};
      BCHR_OFF_IO: rdNext = {24'h000000, ioByte};
      BCHR_OFF_LEGACY: rdNext = {31'h00000000, legacy_reg};
      default: rdNext = 32'h00000000;
    endcase
  end

  // apb answer, one wait state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_reg <= 1'h0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'h0;
    end else begin
      pready_reg <= access;
      pslverr_reg <= 1'h0;
      if (access && !apbReq.pwrite) begin
        prdata_reg <= rdNext;
      end
    end
  end

  // cache line select
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cacheLine_reg <= BCHR_CACHE_RESET;
    end else if (wrEn && apbReq.paddr == BCHR_OFF_CACHE && apbReq.pstrb[0]) begin
      cacheLine_reg <= apbReq.pwdata[5:2];
    end
  end

  // bus numbers and secondary latency
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      upBus_reg <= BCHR_BUS_RESET;
      downBus_reg <= BCHR_BUS_RESET;
      highBus_reg <= BCHR_BUS_RESET;
      secLat_reg <= BCHR_SEC_LAT_RESET;
    end else if (wrEn && apbReq.paddr == BCHR_OFF_BUS) begin
      if (apbReq.pstrb[0]) begin
        upBus_reg <= apbReq.pwdata[7:0];
      end
      if (apbReq.pstrb[1]) begin
        downBus_reg <= apbReq.pwdata[15:8];
      end
      if (apbReq.pstrb[2]) begin
        highBus_reg <= apbReq.pwdata[23:16];
      end
      if (apbReq.pstrb[3]) begin
        secLat_reg <= apbReq.pwdata[31:24];
      end
    end
  end

  // io window base
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ioBase_reg <= BCHR_IO_BASE_RESET;
    end else if (wrEn && apbReq.paddr == BCHR_OFF_IO && apbReq.pstrb[0]) begin
      ioBase_reg <= apbReq.pwdata[7:4];
    end
  end

  // legacy decode control
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      legacy_reg <= 1'b0;
    end else if (wrEn && apbReq.paddr == BCHR_OFF_LEGACY && apbReq.pstrb[0]) begin
      legacy_reg <= apbReq.pwdata[0];
    end
  end

  assign apbRsp.prdata = prdata_reg;
  assign apbRsp.pready = pready_reg;
  assign apbRsp.pslverr = pslverr_reg;
  assign cfgOut.upstreamBus = upBus_reg;
  assign cfgOut.downstreamBus = downBus_reg;
  assign cfgOut.highestBus = highBus_reg;
  assign cfgOut.downstreamLatency = secLat_reg;
  assign cfgOut.ioBase = ioBase_reg;
  assign cfgOut.cacheLine = cacheLine_reg;
  assign cfgOut.legacyDecode = legacy_reg;

  property p_progif;
    @(posedge clk) disable iff (!rst_b)
      (pready_reg && !apbReq.pwrite && apbReq.paddr == BCHR_OFF_CLASS) |->
        prdata_reg[15:8] == {7'h00, legacy_reg};
  endproperty
  a_progif: assert property (p_progif) else $error("prog interface wrong");

  property p_cache_write;
    @(posedge clk) disable iff (!rst_b)
      (wrEn && apbReq.paddr == BCHR_OFF_CACHE && apbReq.pstrb[0]) |=>
        cacheLine_reg == $past(apbReq.pwdata[5:2]);
  endproperty
  a_cache_write: assert property (p_cache_write) else $error("cache bits not stored");

  property p_cache_rsv;
    @(posedge clk) disable iff (!rst_b)
      (pready_reg && !apbReq.pwrite && apbReq.paddr == BCHR_OFF_CACHE) |->
        prdata_reg[1:0] == 2'h0 && prdata_reg[7:6] == 2'h0 && prdata_reg[15:8] == 8'h00;
  endproperty
  a_cache_rsv: assert property (p_cache_rsv) else $error("cache or latency bits nonzero");

  property p_header;
    @(posedge clk) disable iff (!rst_b)
      (pready_reg && !apbReq.pwrite && apbReq.paddr == BCHR_OFF_CACHE) |->
        prdata_reg[23:16] == 8'h01;
  endproperty
  a_header: assert property (p_header) else $error("header layout wrong");

  property p_rsv_range;
    @(posedge clk) disable iff (!rst_b)
      (pready_reg && !apbReq.pwrite && (apbReq.paddr == BCHR_OFF_RSV0 || apbReq.paddr == BCHR_OFF_RSV1)) |->
        prdata_reg == 32'h00000000;
  endproperty
  a_rsv_range: assert property (p_rsv_range) else $error("reserved range nonzero");

  property p_bus_write;
    @(posedge clk) disable iff (!rst_b)
      (wrEn && apbReq.paddr == BCHR_OFF_BUS && apbReq.pstrb == 4'hF) |=>
        {secLat_reg, highBus_reg, downBus_reg, upBus_reg} == $past(apbReq.pwdata);
  endproperty
  a_bus_write: assert property (p_bus_write) else $error("bus numbers not stored");

  property p_io_read;
    @(posedge clk) disable iff (!rst_b)
      (pready_reg && !apbReq.pwrite && apbReq.paddr == BCHR_OFF_IO) |->
        prdata_reg[3:0] == 4'h1 && prdata_reg[7:4] == ioBase_reg;
  endproperty
  a_io_read: assert property (p_io_read) else $error("io base readback wrong");

  property p_class_fixed;
    @(posedge clk) disable iff (!rst_b)
      (pready_reg && !apbReq.pwrite && apbReq.paddr == BCHR_OFF_CLASS) |->
        prdata_reg[31:16] == 16'h0604;
  endproperty
  a_class_fixed: assert property (p_class_fixed) else $error("class code wrong");

  property p_no_err;
    @(posedge clk) disable iff (!rst_b)
      access |=> pready_reg && !apbRsp.pslverr;
  endproperty
  a_no_err: assert property (p_no_err) else $error("access not answered cleanly");

  property p_pready_pulse;
    @(posedge clk) disable iff (!rst_b)
      pready_reg |=> !pready_reg;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");

  property p_pready_cause;
    @(posedge clk) disable iff (!rst_b)
      !access |=> !pready_reg;
  endproperty
  a_pready_cause: assert property (p_pready_cause) else $error("pready without access");

  property p_answer_once;
    @(posedge clk) disable iff (!rst_b)
      pready_reg |-> $past(access);
  endproperty
  a_answer_once: assert property (p_answer_once) else $error("answer not preceded by access");

  property p_cache_keep;
    @(posedge clk) disable iff (!rst_b)
      !(wrEn && apbReq.paddr == BCHR_OFF_CACHE && apbReq.pstrb[0]) |=> $stable(cacheLine_reg);
  endproperty
  a_cache_keep: assert property (p_cache_keep) else $error("cache bits changed without write");

  property p_cache_read;
    @(posedge clk) disable iff (!rst_b)
      (pready_reg && !apbReq.pwrite && apbReq.paddr == BCHR_OFF_CACHE) |->
        prdata_reg[5:2] == cacheLine_reg;
  endproperty
  a_cache_read: assert property (p_cache_read) else $error("cache bits readback wrong");

  property p_pri_lat;
    @(posedge clk) disable iff (!rst_b)
      (pready_reg && !apbReq.pwrite && apbReq.paddr == BCHR_OFF_CACHE) |->
        prdata_reg[15:8] == 8'h00;
  endproperty
  a_pri_lat: assert property (p_pri_lat) else $error("primary latency nonzero");

  property p_self_test;
    @(posedge clk) disable iff (!rst_b)
      (pready_reg && !apbReq.pwrite && apbReq.paddr == BCHR_OFF_CACHE) |->
        prdata_reg[31:24] == 8'h00;
  endproperty
  a_self_test: assert property (p_self_test) else $error("self test byte nonzero");

  property p_bus_keep;
    @(posedge clk) disable iff (!rst_b)
      !(wrEn && apbReq.paddr == BCHR_OFF_BUS) |=>
        $stable({secLat_reg, highBus_reg, downBus_reg, upBus_reg});
  endproperty
  a_bus_keep: assert property (p_bus_keep) else $error("bus numbers changed without write");

  property p_bus_lane0;
    @(posedge clk) disable iff (!rst_b)
      (wrEn && apbReq.paddr == BCHR_OFF_BUS && apbReq.pstrb[0]) |=>
        upBus_reg == $past(apbReq.pwdata[7:0]);
  endproperty
  a_bus_lane0: assert property (p_bus_lane0) else $error("upstream bus not stored");

  property p_bus_lane1;
    @(posedge clk) disable iff (!rst_b)
      (wrEn && apbReq.paddr == BCHR_OFF_BUS && apbReq.pstrb[1]) |=>
        downBus_reg == $past(apbReq.pwdata[15:8]);
  endproperty
  a_bus_lane1: assert property (p_bus_lane1) else $error("downstream bus not stored");

  property p_bus_lane2;
    @(posedge clk) disable iff (!rst_b)
      (wrEn && apbReq.paddr == BCHR_OFF_BUS && apbReq.pstrb[2]) |=>
        highBus_reg == $past(apbReq.pwdata[23:16]);
  endproperty
  a_bus_lane2: assert property (p_bus_lane2) else $error("highest bus not stored");

  property p_sec_lat_lane;
    @(posedge clk) disable iff (!rst_b)
      (wrEn && apbReq.paddr == BCHR_OFF_BUS && apbReq.pstrb[3]) |=>
        secLat_reg == $past(apbReq.pwdata[31:24]);
  endproperty
  a_sec_lat_lane: assert property (p_sec_lat_lane) else $error("secondary latency not stored");

  property p_bus_read;
    @(posedge clk) disable iff (!rst_b)
      (pready_reg && !apbReq.pwrite && apbReq.paddr == BCHR_OFF_BUS) |->
        prdata_reg == {secLat_reg, highBus_reg, downBus_reg, upBus_reg};
  endproperty
  a_bus_read: assert property (p_bus_read) else $error("bus numbers readback wrong");

  property p_io_write;
    @(posedge clk) disable iff (!rst_b)
      (wrEn && apbReq.paddr == BCHR_OFF_IO && apbReq.pstrb[0]) |=>
        ioBase_reg == $past(apbReq.pwdata[7:4]);
  endproperty
  a_io_write: assert property (p_io_write) else $error("io base not stored");

  property p_io_keep;
    @(posedge clk) disable iff (!rst_b)
      !(wrEn && apbReq.paddr == BCHR_OFF_IO && apbReq.pstrb[0]) |=> $stable(ioBase_reg);
  endproperty
  a_io_keep: assert property (p_io_keep) else $error("io base changed without write");

  property p_legacy_write;
    @(posedge clk) disable iff (!rst_b)
      (wrEn && apbReq.paddr == BCHR_OFF_LEGACY && apbReq.pstrb[0]) |=>
        legacy_reg == $past(apbReq.pwdata[0]);
  endproperty
  a_legacy_write: assert property (p_legacy_write) else $error("legacy bit not stored");

  property p_legacy_keep;
    @(posedge clk) disable iff (!rst_b)
      !(wrEn && apbReq.paddr == BCHR_OFF_LEGACY && apbReq.pstrb[0]) |=> $stable(legacy_reg);
  endproperty
  a_legacy_keep: assert property (p_legacy_keep) else $error("legacy bit changed without write");

  property p_unaligned;
    @(posedge clk) disable iff (!rst_b)
      (pready_reg && !apbReq.pwrite && apbReq.paddr[1:0] != 2'h0) |->
        prdata_reg == 32'h00000000;
  endproperty
  a_unaligned: assert property (p_unaligned) else $error("unaligned read nonzero");

  property p_rsv_write;
    @(posedge clk) disable iff (!rst_b)
      (wrEn && (apbReq.paddr == BCHR_OFF_RSV0 || apbReq.paddr == BCHR_OFF_RSV1)) |=>
        $stable({cacheLine_reg, upBus_reg, downBus_reg, highBus_reg, secLat_reg, ioBase_reg, legacy_reg});
  endproperty
  a_rsv_write: assert property (p_rsv_write) else $error("reserved write changed state");

  property p_read_holds;
    @(posedge clk) disable iff (!rst_b)
      !(access && !apbReq.pwrite) |=> $stable(prdata_reg);
  endproperty
  a_read_holds: assert property (p_read_holds) else $error("read data changed without read");
endmodule

/* File: bchr_host.sv */
// Purpose: host-side apb master model for the header register bank
// Assumes: one transfer at a time, strobes given per call
// Notes: waits for pready without limit, the bench watchdog covers hangs
`timescale 1ns/1ps
module bchr_host
  import bchr_pkg::*;
(
  input wire logic clk,
  input wire bchr_pkg::bchr_apb_rsp_t apbRsp,
  output bchr_pkg::bchr_apb_req_t apbReq
);
  logic lastErr;
  initial apbReq = '0;
  // setup cycle, then access phase held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, input logic [3:0] strb,
                      output logic [31:0] rdata);
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata, pstrb: strb};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (apbRsp.pready !== 1'b1);
    rdata = apbRsp.prdata;
    lastErr = apbRsp.pslverr;
    apbReq <= '0;
  endtask
endmodule

/* File: tb.sv */
// Purpose: self-checking bench for the header register bank
// Assumes: host model drives every apb transfer
// Notes: revision value below is arbitrary
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
  import bchr_pkg::*;
  localparam logic [7:0] REV = 8'h5A;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  bchr_apb_req_t apbReq;
  bchr_apb_rsp_t apbRsp;
  bchr_cfg_t cfgOut;
  logic [31:0] rd;
  int fails = 0;
  int compares = 0;
  always #50 clk = ~clk;
  bchr_regs #(.REVISION(REV)) dut (.clk(clk), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp), .cfgOut(cfgOut));
  bchr_host host (.clk(clk), .apbRsp(apbRsp), .apbReq(apbReq));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, 4'hF, rd);
  endtask
  task automatic wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    host.xfer(1'b1, a, d, s, rd);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    host.xfer(1'b0, a, 32'h0, 4'h0, rd);
    `CHK(n, e, rd)
  endtask
  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rchk(8'h08, {8'h06, 8'h04, 8'h00, REV}, "class");
    rchk(8'h0C, 32'h0001_0000, "hdr");
    rchk(8'h18, 32'h4000_0000, "bus");
    rchk(8'h1C, 32'h0000_0001, "iob");
    wr(8'h0C, 32'hFFFF_FFFF);
    rchk(8'h0C, 32'h0001_003C, "cacheall");
    wr(8'h0C, 32'h0000_00A4);
    rchk(8'h0C, 32'h0001_0024, "cache");
    wr(8'h08, 32'hFFFF_FFFF);
    rchk(8'h08, {8'h06, 8'h04, 8'h00, REV}, "classro");
    wr(8'h98, 32'h0000_0001);
    rchk(8'h08, {8'h06, 8'h04, 8'h01, REV}, "progon");
    `CHK("legacy", 1'b1, cfgOut.legacyDecode)
    wr(8'h98, 32'h0000_0000);
    rchk(8'h08, {8'h06, 8'h04, 8'h00, REV}, "progoff");
    wr(8'h10, 32'hFFFF_FFFF);
    wr(8'h14, 32'hFFFF_FFFF);
    rchk(8'h10, 32'h0, "rsv0");
    rchk(8'h14, 32'h0, "rsv1");
    wr(8'h18, 32'h1234_5678);
    rchk(8'h18, 32'h1234_5678, "busw");
    wr(8'h1C, 32'hFFFF_FFFF);
    rchk(8'h1C, 32'h0000_00F1, "iobw");
    `CHK("cfg", {8'h78, 8'h56, 8'h34, 8'h12, 4'hF, 4'h9, 1'b0}, cfgOut)
    wrs(8'h18, 32'hAABB_CCDD, 4'h2);
    rchk(8'h18, 32'h1234_CC78, "buslane");
    wrs(8'h0C, 32'h0000_00FF, 4'hE);
    rchk(8'h0C, 32'h0001_0024, "cachelane");
    rchk(8'h09, 32'h0, "unaligned");
    `CHK("slverr", 1'b0, host.lastErr)
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rchk(8'h18, 32'h4000_0000, "busrst");
    rchk(8'h0C, 32'h0001_0000, "cachrst");
    rchk(8'h1C, 32'h0000_0001, "iobrst");
    `CHK("cfgrst", {8'h00, 8'h00, 8'h00, 8'h40, 4'h0, 4'h0, 1'b0}, cfgOut)
    print_verdict();
  end
endmodule
